//--- rtl/dpm_pkg.sv
package dpm_pkg;
   // clock and activity timing
   localparam int CLK_NS = 10;
   localparam int TICK_MS = 4;
   localparam int TICK_NS = TICK_MS * 1_000_000;
   localparam int TICK_CYCLES = TICK_NS / CLK_NS;
   localparam int RAMP_MS = 100;
   localparam int SEC_MS = 1000;
   localparam int RAMP_TICKS = RAMP_MS / TICK_MS;
   localparam int SEC_TICKS = SEC_MS / TICK_MS;

   // widths and depths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CUR_W = 12;
   localparam int CNT_W = 24;
   localparam int DAC_W = 12;
   localparam int HIST_DEPTH = 1024;
   localparam int RATE_LOG2 = 3;

   // register byte offsets
   localparam logic [7:0] REG_CONTROL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_HV_LIMIT = 8'h08;
   localparam logic [7:0] REG_AUX_LIMIT = 8'h0c;
   localparam logic [7:0] REG_PERSIST = 8'h10;
   localparam logic [7:0] REG_RATE_LIMIT = 8'h14;
   localparam logic [7:0] REG_LOW_V = 8'h18;
   localparam logic [7:0] REG_NOMINAL_V = 8'h1c;
   localparam logic [7:0] REG_RAMP_STEP = 8'h20;
   localparam logic [7:0] REG_RAMP_INTERVAL = 8'h24;
   localparam logic [7:0] REG_CEILING = 8'h28;
   localparam logic [7:0] REG_DAC = 8'h2c;
   localparam logic [7:0] REG_DOOR_CTRL = 8'h30;
   localparam logic [7:0] REG_DOOR_TIMER = 8'h34;
   localparam logic [7:0] REG_MOTOR_TIMER = 8'h38;
   localparam logic [7:0] REG_DOOR_AUX_LIMIT = 8'h3c;
   localparam logic [7:0] REG_HIST_INDEX = 8'h40;
   localparam logic [7:0] REG_HIST_DATA = 8'h44;
   localparam logic [7:0] REG_HIST_WPTR = 8'h48;
   localparam logic [7:0] REG_AVG_A = 8'h4c;
   localparam logic [7:0] REG_AVG_B = 8'h50;
   localparam logic [7:0] REG_CLP_COUNT = 8'h54;

   // control bits
   localparam int CTL_HV_ON = 0;
   localparam int CTL_RAMP_GO = 1;
   localparam int CTL_RAMP_ABORT = 2;

   // status bits
   localparam int ST_HV_FIRST = 0;
   localparam int ST_HV_TRIP = 1;
   localparam int ST_CRP_TRIP = 2;
   localparam int ST_DOOR_STOP = 3;
   localparam int ST_AUX_DOOR = 4;
   localparam int ST_RAMP_ACTIVE = 5;
   localparam int ST_RAMP_WAITING = 6;
   localparam int ST_W = 5;

   // reset defaults
   localparam logic [11:0] DEF_HV_LIMIT = 12'h0c00;
   localparam logic [11:0] DEF_AUX_LIMIT = 12'h0c00;
   localparam logic [15:0] DEF_PERSIST = 16'h0004;
   localparam logic [23:0] DEF_RATE_LIMIT = 24'h00_ffff;
   localparam logic [11:0] DEF_LOW_V = 12'h0100;
   localparam logic [11:0] DEF_NOMINAL_V = 12'h0800;
   localparam logic [11:0] DEF_RAMP_STEP = 12'h0010;
   localparam logic [7:0] DEF_RAMP_INTERVAL = 8'h01;
   localparam logic [11:0] DEF_CEILING = 12'h0800;
   localparam logic [11:0] DEF_DOOR_AUX_LIMIT = 12'h0c00;
   localparam int DOOR_NOMINAL_S = 3 * 60;
   localparam int LATCH_STOP_S = 2;
   localparam int AUX_DOOR_CONSEC = 3;

   // diagnostic codes
   localparam logic [3:0] DIAG_NONE = 4'h0;
   localparam logic [3:0] DIAG_HV_FIRST = 4'h1;
   localparam logic [3:0] DIAG_HV_TRIP = 4'h2;
   localparam logic [3:0] DIAG_AUX_DOOR = 4'h3;
   localparam logic [3:0] DIAG_CRP = 4'h4;

   localparam logic [1:0] DIR_STOP = 2'h0;

   typedef enum logic [1:0] {RAMP_IDLE, RAMP_STEP, RAMP_WAIT} dpm_ramp_state_t;

   typedef struct packed {
      logic motor_pwr;
      logic actuator_pwr;
      logic motor_en;
      logic actuator_en;
      logic [1:0] dir;
      logic motor_override;
   } dpm_door_t;
endpackage : dpm_pkg

//--- rtl/dpm_top.sv
// How it works
// - check both currents every 4 ms
// - keep last 1024 current samples
// - first over-limit posts diagnostic, rest count
// - in-limit sample zeroes over-limit counter
// - count reaching persistence switches supply off
// - over-current reported without switching off
// - each second buffer counters, average them
// - average at limit drops to low voltage
// - count-rate violation aborts running ramp
// - ramp from present level toward nominal
// - wait ramp interval after each step
// - ramp never writes ceiling; output clamped
// - ramp keeps state plus two status bits
// - door timer counts seconds, expiry stops
// - unexpired: three aux over-limits stop door
// - latch change reloads door timer two seconds
// - door stop clears power, enables, direction
// - defaults at reset, changeable by write
// - protection tick runs 250 per second
// - ramp step activity every 0.1 second
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module dpm_top #(
   parameter int TICK_CYCLES = dpm_pkg::TICK_CYCLES,
   parameter int RATE_LOG2 = dpm_pkg::RATE_LOG2
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   output logic [31:0] o_rd_data,
   input wire logic [11:0] i_hv_current,
   input wire logic [11:0] i_aux_current,
   input wire logic [23:0] i_front_end_count_seg_a,
   input wire logic [23:0] i_front_end_count_seg_b,
   input wire logic i_latch,
   output logic o_hv_enable,
   output logic [11:0] o_hv_dac,
   output dpm_pkg::dpm_door_t o_door,
   output logic o_diag_valid,
   output logic [3:0] o_diag_code
);
   localparam int RATE_DEPTH = 1 << RATE_LOG2;

   function automatic logic [11:0] min12(input logic [11:0] a, input logic [11:0] b);
      min12 = (a < b) ? a : b;
   endfunction : min12

   function automatic logic wr_at(input logic stb, input logic [7:0] a, input logic [7:0] off);
      wr_at = stb && (a == off);
   endfunction : wr_at

   // divider and strobes
   logic [31:0] tick_cnt;
   logic tick;
   logic [7:0] ramp_div;
   logic [7:0] sec_div;
   logic stb_ramp;
   logic stb_sec;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         tick_cnt <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
         tick_cnt <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
         tick <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ramp_div <= 8'h00;
         sec_div <= 8'h00;
         stb_ramp <= 1'b0;
         stb_sec <= 1'b0;
      end else begin
         stb_ramp <= tick && (ramp_div == 8'(dpm_pkg::RAMP_TICKS - 1));
         stb_sec <= tick && (sec_div == 8'(dpm_pkg::SEC_TICKS - 1));
         if (tick) begin
            ramp_div <= (ramp_div == 8'(dpm_pkg::RAMP_TICKS - 1)) ? 8'h00 : ramp_div + 8'h01;
            sec_div <= (sec_div == 8'(dpm_pkg::SEC_TICKS - 1)) ? 8'h00 : sec_div + 8'h01;
         end
      end
   end

   // parameters, all loaded at reset and writable
   logic [11:0] hv_limit;
   logic [11:0] aux_limit;
   logic [15:0] persist;
   logic [23:0] rate_limit;
   logic [11:0] low_v;
   logic [11:0] nominal_v;
   logic [11:0] ramp_step;
   logic [7:0] ramp_interval;
   logic [11:0] ceiling;
   logic [11:0] door_aux_limit;
   logic [9:0] hist_index;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         hv_limit <= dpm_pkg::DEF_HV_LIMIT;
         aux_limit <= dpm_pkg::DEF_AUX_LIMIT;
         persist <= dpm_pkg::DEF_PERSIST;
         rate_limit <= dpm_pkg::DEF_RATE_LIMIT;
         low_v <= dpm_pkg::DEF_LOW_V;
         nominal_v <= dpm_pkg::DEF_NOMINAL_V;
         ramp_step <= dpm_pkg::DEF_RAMP_STEP;
         ramp_interval <= dpm_pkg::DEF_RAMP_INTERVAL;
         ceiling <= dpm_pkg::DEF_CEILING;
         door_aux_limit <= dpm_pkg::DEF_DOOR_AUX_LIMIT;
         hist_index <= 10'h000;
      end else if (i_wr_stb) begin
         unique case (i_addr)
            dpm_pkg::REG_HV_LIMIT: hv_limit <= i_wr_data[11:0];
            dpm_pkg::REG_AUX_LIMIT: aux_limit <= i_wr_data[11:0];
            dpm_pkg::REG_PERSIST: persist <= i_wr_data[15:0];
            dpm_pkg::REG_RATE_LIMIT: rate_limit <= i_wr_data[23:0];
            dpm_pkg::REG_LOW_V: low_v <= i_wr_data[11:0];
            dpm_pkg::REG_NOMINAL_V: nominal_v <= i_wr_data[11:0];
            dpm_pkg::REG_RAMP_STEP: ramp_step <= i_wr_data[11:0];
            dpm_pkg::REG_RAMP_INTERVAL: ramp_interval <= i_wr_data[7:0];
            dpm_pkg::REG_CEILING: ceiling <= i_wr_data[11:0];
            dpm_pkg::REG_DOOR_AUX_LIMIT: door_aux_limit <= i_wr_data[11:0];
            dpm_pkg::REG_HIST_INDEX: hist_index <= i_wr_data[9:0];
            default: ;
         endcase
      end
   end

   // current sample history
   logic [23:0] hist [dpm_pkg::HIST_DEPTH];
   logic [9:0] hist_wptr;

   always_ff @(posedge i_clk_sys) begin
      if (tick) begin
         hist[hist_wptr] <= {i_aux_current, i_hv_current};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         hist_wptr <= 10'h000;
      end else if (tick) begin
         hist_wptr <= hist_wptr + 10'h001;
      end
   end

   // current limit guard
   logic clp_over;
   logic [15:0] clp_count;
   logic [15:0] clp_next;
   logic clp_first;
   logic clp_trip;

   always_comb begin
      clp_over = (i_hv_current > hv_limit) || (i_aux_current > aux_limit);
      clp_next = (clp_count == 16'hffff) ? clp_count : clp_count + 16'h0001;
      clp_first = tick && clp_over && (clp_count == 16'h0000);
      clp_trip = tick && clp_over && (clp_next >= persist);
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         clp_count <= 16'h0000;
      end else if (tick) begin
         clp_count <= clp_over ? clp_next : 16'h0000;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_hv_enable <= 1'b0;
      end else if (clp_trip) begin
         o_hv_enable <= 1'b0;
      end else if (wr_at(i_wr_stb, i_addr, dpm_pkg::REG_CONTROL)) begin
         o_hv_enable <= i_wr_data[dpm_pkg::CTL_HV_ON];
      end
   end

   // count rate guard
   logic [23:0] rate_a [RATE_DEPTH];
   logic [23:0] rate_b [RATE_DEPTH];
   logic [RATE_LOG2-1:0] rate_ptr;
   logic [23+RATE_LOG2:0] sum_a;
   logic [23+RATE_LOG2:0] sum_b;
   logic [23:0] avg_a;
   logic [23:0] avg_b;
   logic crp_check;
   logic crp_viol;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         for (int i = 0; i < RATE_DEPTH; i++) begin
            rate_a[i] <= 24'h00_0000;
            rate_b[i] <= 24'h00_0000;
         end
         rate_ptr <= '0;
         sum_a <= '0;
         sum_b <= '0;
         crp_check <= 1'b0;
      end else begin
         crp_check <= stb_sec;
         if (stb_sec) begin
            rate_a[rate_ptr] <= i_front_end_count_seg_a;
            rate_b[rate_ptr] <= i_front_end_count_seg_b;
            sum_a <= sum_a - (24+RATE_LOG2)'(rate_a[rate_ptr]) + (24+RATE_LOG2)'(i_front_end_count_seg_a);
            sum_b <= sum_b - (24+RATE_LOG2)'(rate_b[rate_ptr]) + (24+RATE_LOG2)'(i_front_end_count_seg_b);
            rate_ptr <= rate_ptr + 1'b1;
         end
      end
   end

   always_comb begin
      avg_a = sum_a[23+RATE_LOG2:RATE_LOG2];
      avg_b = sum_b[23+RATE_LOG2:RATE_LOG2];
      crp_viol = crp_check && ((avg_a >= rate_limit) || (avg_b >= rate_limit));
   end

   // voltage ramp and converter setting
   dpm_pkg::dpm_ramp_state_t ramp_state;
   logic [7:0] ramp_wait;
   logic [11:0] dac;
   logic [11:0] ramp_target;
   logic [12:0] ramp_sum;

   always_comb begin
      ramp_target = min12(nominal_v, ceiling);
      ramp_sum = {1'b0, dac} + {1'b0, ramp_step};
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ramp_state <= dpm_pkg::RAMP_IDLE;
         ramp_wait <= 8'h00;
         dac <= 12'h000;
      end else if (crp_viol) begin
         ramp_state <= dpm_pkg::RAMP_IDLE;
         if (dac > low_v) begin
            dac <= low_v;
         end
      end else if (wr_at(i_wr_stb, i_addr, dpm_pkg::REG_DAC)) begin
         dac <= min12(i_wr_data[11:0], ceiling);
      end else if (wr_at(i_wr_stb, i_addr, dpm_pkg::REG_CONTROL) && i_wr_data[dpm_pkg::CTL_RAMP_ABORT]) begin
         ramp_state <= dpm_pkg::RAMP_IDLE;
      end else if (wr_at(i_wr_stb, i_addr, dpm_pkg::REG_CONTROL) && i_wr_data[dpm_pkg::CTL_RAMP_GO]) begin
         ramp_state <= dpm_pkg::RAMP_STEP;
      end else if (stb_ramp) begin
         unique case (ramp_state)
            dpm_pkg::RAMP_IDLE: ;
            dpm_pkg::RAMP_STEP: begin
               if (dac >= ramp_target) begin
                  ramp_state <= dpm_pkg::RAMP_IDLE;
               end else begin
                  // overflowed sum saturates at the target
                  dac <= (ramp_sum[12] || ramp_sum[11:0] > ramp_target) ? ramp_target : ramp_sum[11:0];
                  ramp_wait <= ramp_interval;
                  ramp_state <= dpm_pkg::RAMP_WAIT;
               end
            end
            dpm_pkg::RAMP_WAIT: begin
               if (ramp_wait <= 8'h01) begin
                  ramp_state <= dpm_pkg::RAMP_STEP;
               end else begin
                  ramp_wait <= ramp_wait - 8'h01;
               end
            end
         endcase
      end
   end

   // ceiling may be lowered under a running setting, so clamp on the way out
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_hv_dac <= 12'h000;
      end else begin
         o_hv_dac <= min12(dac, ceiling);
      end
   end

   // door protection
   logic [15:0] door_timer;
   logic [15:0] motor_timer;
   logic [1:0] aux_door_cnt;
   logic latch_s1;
   logic latch_s2;
   logic latch_s3;
   logic latch_stable;
   logic latch_change;
   logic aux_door_hit;
   logic door_stop;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         latch_s1 <= 1'b0;
         latch_s2 <= 1'b0;
         latch_s3 <= 1'b0;
         latch_stable <= 1'b0;
      end else begin
         latch_s1 <= i_latch;
         latch_s2 <= latch_s1;
         latch_s3 <= latch_s2;
         if (latch_s2 == latch_s3) begin
            latch_stable <= latch_s3;
         end
      end
   end

   always_comb begin
      // a latch that reads high after reset differs from the cleared stable state and counts as a change
      latch_change = (latch_s2 == latch_s3) && (latch_s3 != latch_stable);
      aux_door_hit = (door_timer != 16'h0000) && (i_aux_current >= door_aux_limit)
                     && (aux_door_cnt == 2'(dpm_pkg::AUX_DOOR_CONSEC - 1));
      door_stop = stb_sec && ((door_timer == 16'h0001) || (door_timer == 16'h0000) || aux_door_hit);
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         door_timer <= 16'(dpm_pkg::DOOR_NOMINAL_S);
         aux_door_cnt <= 2'h0;
      end else begin
         if (wr_at(i_wr_stb, i_addr, dpm_pkg::REG_DOOR_TIMER)) begin
            door_timer <= i_wr_data[15:0];
         end else if (latch_change) begin
            door_timer <= 16'(dpm_pkg::LATCH_STOP_S);
         end else if (stb_sec && door_timer != 16'h0000) begin
            door_timer <= door_timer - 16'h0001;
         end
         if (stb_sec) begin
            if (door_timer != 16'h0000 && i_aux_current >= door_aux_limit) begin
               aux_door_cnt <= (aux_door_cnt == 2'h3) ? aux_door_cnt : aux_door_cnt + 2'h1;
            end else begin
               aux_door_cnt <= 2'h0;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_door <= '0;
         motor_timer <= 16'h0000;
      end else if (door_stop) begin
         o_door.motor_pwr <= 1'b0;
         o_door.actuator_pwr <= 1'b0;
         o_door.motor_en <= 1'b0;
         o_door.actuator_en <= 1'b0;
         o_door.dir <= dpm_pkg::DIR_STOP;
         o_door.motor_override <= 1'b0;
         motor_timer <= 16'h0000;
      end else begin
         if (wr_at(i_wr_stb, i_addr, dpm_pkg::REG_DOOR_CTRL)) begin
            o_door <= i_wr_data[6:0];
         end
         if (wr_at(i_wr_stb, i_addr, dpm_pkg::REG_MOTOR_TIMER)) begin
            motor_timer <= i_wr_data[15:0];
         end else if (stb_sec && motor_timer != 16'h0000) begin
            motor_timer <= motor_timer - 16'h0001;
         end
      end
   end

   // diagnostics and sticky status
   logic [dpm_pkg::ST_W-1:0] status;
   logic [dpm_pkg::ST_W-1:0] status_set;

   always_comb begin
      status_set = '0;
      status_set[dpm_pkg::ST_HV_FIRST] = clp_first;
      status_set[dpm_pkg::ST_HV_TRIP] = clp_trip;
      status_set[dpm_pkg::ST_CRP_TRIP] = crp_viol;
      status_set[dpm_pkg::ST_DOOR_STOP] = door_stop;
      status_set[dpm_pkg::ST_AUX_DOOR] = stb_sec && aux_door_hit;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         status <= '0;
      end else if (wr_at(i_wr_stb, i_addr, dpm_pkg::REG_STATUS)) begin
         status <= (status & ~i_wr_data[dpm_pkg::ST_W-1:0]) | status_set;
      end else begin
         status <= status | status_set;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_diag_valid <= 1'b0;
         o_diag_code <= dpm_pkg::DIAG_NONE;
      end else begin
         o_diag_valid <= clp_trip || clp_first || crp_viol || (stb_sec && aux_door_hit);
         if (clp_trip) begin
            o_diag_code <= dpm_pkg::DIAG_HV_TRIP;
         end else if (clp_first) begin
            o_diag_code <= dpm_pkg::DIAG_HV_FIRST;
         end else if (stb_sec && aux_door_hit) begin
            o_diag_code <= dpm_pkg::DIAG_AUX_DOOR;
         end else if (crp_viol) begin
            o_diag_code <= dpm_pkg::DIAG_CRP;
         end else begin
            o_diag_code <= dpm_pkg::DIAG_NONE;
         end
      end
   end

   // register read port, data valid only in the cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !i_rd_stb) begin
         o_rd_data <= 32'h0000_0000;
      end else begin
         unique case (i_addr)
            dpm_pkg::REG_CONTROL: o_rd_data <= {31'h0000_0000, o_hv_enable};
            dpm_pkg::REG_STATUS: o_rd_data <= {25'h000_0000, ramp_state == dpm_pkg::RAMP_WAIT,
                                               ramp_state != dpm_pkg::RAMP_IDLE, status};
            dpm_pkg::REG_HV_LIMIT: o_rd_data <= {20'h0_0000, hv_limit};
            dpm_pkg::REG_AUX_LIMIT: o_rd_data <= {20'h0_0000, aux_limit};
            dpm_pkg::REG_PERSIST: o_rd_data <= {16'h0000, persist};
            dpm_pkg::REG_RATE_LIMIT: o_rd_data <= {8'h00, rate_limit};
            dpm_pkg::REG_LOW_V: o_rd_data <= {20'h0_0000, low_v};
            dpm_pkg::REG_NOMINAL_V: o_rd_data <= {20'h0_0000, nominal_v};
            dpm_pkg::REG_RAMP_STEP: o_rd_data <= {20'h0_0000, ramp_step};
            dpm_pkg::REG_RAMP_INTERVAL: o_rd_data <= {24'h00_0000, ramp_interval};
            dpm_pkg::REG_CEILING: o_rd_data <= {20'h0_0000, ceiling};
            dpm_pkg::REG_DAC: o_rd_data <= {20'h0_0000, dac};
            dpm_pkg::REG_DOOR_CTRL: o_rd_data <= {25'h000_0000, o_door};
            dpm_pkg::REG_DOOR_TIMER: o_rd_data <= {16'h0000, door_timer};
            dpm_pkg::REG_MOTOR_TIMER: o_rd_data <= {16'h0000, motor_timer};
            dpm_pkg::REG_DOOR_AUX_LIMIT: o_rd_data <= {20'h0_0000, door_aux_limit};
            dpm_pkg::REG_HIST_INDEX: o_rd_data <= {22'h00_0000, hist_index};
            dpm_pkg::REG_HIST_DATA: o_rd_data <= {8'h00, hist[hist_index]};
            dpm_pkg::REG_HIST_WPTR: o_rd_data <= {22'h00_0000, hist_wptr};
            dpm_pkg::REG_AVG_A: o_rd_data <= {8'h00, avg_a};
            dpm_pkg::REG_AVG_B: o_rd_data <= {8'h00, avg_b};
            dpm_pkg::REG_CLP_COUNT: o_rd_data <= {16'h0000, clp_count};
            default: o_rd_data <= 32'h0000_0000;
         endcase
      end
   end
endmodule : dpm_top
`default_nettype wire

//--- tb/dpm_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dpm_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   input wire logic [31:0] o_rd_data,
   input wire logic o_hv_enable,
   input wire logic [11:0] o_hv_dac,
   input wire dpm_pkg::dpm_door_t o_door,
   input wire logic o_diag_valid,
   input wire logic [3:0] o_diag_code
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   property p_pulse; o_diag_valid |=> !o_diag_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("diag pulse too long");
   property p_code; o_diag_valid |-> o_diag_code inside {[dpm_pkg::DIAG_HV_FIRST:dpm_pkg::DIAG_CRP]}; endproperty
   a_code: assert property (p_code) else $error("bad diag code");
   property p_trip; o_diag_valid && o_diag_code == dpm_pkg::DIAG_HV_TRIP |-> !o_hv_enable; endproperty
   a_trip: assert property (p_trip) else $error("supply on after trip");
   property p_fall; $fell(o_hv_enable) && !$past(i_wr_stb) |-> o_diag_valid && o_diag_code == dpm_pkg::DIAG_HV_TRIP;
   endproperty
   a_fall: assert property (p_fall) else $error("supply off without trip");
   property p_rise; $rose(o_hv_enable) |-> $past(i_wr_stb) && $past(i_addr) == dpm_pkg::REG_CONTROL; endproperty
   a_rise: assert property (p_rise) else $error("supply on without command");
   property p_door; o_diag_valid && o_diag_code == dpm_pkg::DIAG_AUX_DOOR |-> ##[0:1] o_door == 7'h00; endproperty
   a_door: assert property (p_door) else $error("door not stopped");
   property p_crp; o_diag_valid && o_diag_code == dpm_pkg::DIAG_CRP |=> o_hv_dac <= $past(o_hv_dac); endproperty
   a_crp: assert property (p_crp) else $error("rate action raised voltage");
   property p_rd; !$past(i_rd_stb) |-> o_rd_data == 32'h0000_0000; endproperty
   a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule : dpm_chk
bind dpm_top dpm_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wr_stb(i_wr_stb),
   .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_hv_enable(o_hv_enable), .o_hv_dac(o_hv_dac),
   .o_door(o_door), .o_diag_valid(o_diag_valid), .o_diag_code(o_diag_code));
`default_nettype wire

//--- tb/dpm_partner.sv
`timescale 1ns/1ns
`default_nettype none
module dpm_partner (
   input wire logic i_hv_enable,
   input wire dpm_pkg::dpm_door_t i_door,
   input wire logic i_over,
   input wire logic i_aux_hi,
   input wire logic i_burst,
   input wire logic i_latch_cmd,
   output logic [11:0] o_hv_current,
   output logic [11:0] o_aux_current,
   output logic [23:0] o_count,
   output logic o_latch
);
   // supply draws current only while switched on
   always_comb o_hv_current = !i_hv_enable ? 12'h000 : (i_over ? 12'hc01 : 12'h400);
   // aux load follows the door motor power
   always_comb o_aux_current = (i_aux_hi && i_door.motor_pwr) ? 12'hc00 : 12'h080;
   always_comb o_count = i_burst ? 24'h00_0800 : 24'h00_0001;
   always_comb o_latch = i_latch_cmd;
endmodule : dpm_partner
`default_nettype wire

//--- tb/dpm_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module dpm_top_test;
   logic clk = 1'b0, rst = 1'b1, ws = 1'b0, rs = 1'b0, over = 1'b0, aux_hi = 1'b0, burst = 1'b0, lcmd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rdat, q;
   logic [11:0] hv_cur, aux_cur, dac;
   logic [23:0] cnt;
   logic latch, hv_en, dv;
   logic [3:0] dc;
   dpm_pkg::dpm_door_t door;
   int n_fail = 0, tests_run = 0, n;
   always #5 clk = ~clk;
   dpm_top #(.TICK_CYCLES(20), .RATE_LOG2(3)) dut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wd),
      .i_wr_stb(ws), .i_rd_stb(rs), .o_rd_data(rdat), .i_hv_current(hv_cur), .i_aux_current(aux_cur),
      .i_front_end_count_seg_a(cnt), .i_front_end_count_seg_b(cnt), .i_latch(latch), .o_hv_enable(hv_en),
      .o_hv_dac(dac), .o_door(door), .o_diag_valid(dv), .o_diag_code(dc));
   dpm_partner u_far (.i_hv_enable(hv_en), .i_door(door), .i_over(over), .i_aux_hi(aux_hi), .i_burst(burst),
      .i_latch_cmd(lcmd), .o_hv_current(hv_cur), .o_aux_current(aux_cur), .o_count(cnt), .o_latch(latch));
   task automatic summarize();
      if (n_fail == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a; wd <= d; ws <= 1'b1;
      @(posedge clk);
      ws <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a; rs <= 1'b1;
      @(posedge clk);
      rs <= 1'b0;
      #1 d = rdat;
   endtask : rd
   // bounded waits; running out ends the run
   task automatic wdiag(input logic [3:0] c, input int lim, output int t);
      for (t = 0; t < lim; t++) begin
         @(posedge clk);
         #1;
         if (dv === 1'b1 && dc === c) return;
      end
      chk(32'(c), 32'h0000_0000);
      summarize();
   endtask : wdiag
   task automatic wdac(input logic [11:0] v, input int lim, output int t);
      for (t = 0; t < lim; t++) begin
         @(posedge clk);
         #1;
         if (dac === v) return;
      end
      chk(32'(dac), 32'(v));
      summarize();
   endtask : wdac
   task automatic t_defaults();
      rd(dpm_pkg::REG_HV_LIMIT, q); chk(q, 32'h0000_0c00);
      rd(dpm_pkg::REG_PERSIST, q); chk(q, 32'h0000_0004);
      rd(dpm_pkg::REG_DOOR_TIMER, q); chk(q, 32'h0000_00b4);
      rd(8'hfc, q); chk(q, 32'h0000_0000);
   endtask : t_defaults
   task automatic t_clp();
      wr(dpm_pkg::REG_PERSIST, 32'h0000_0003);
      wr(dpm_pkg::REG_CONTROL, 32'h0000_0001);
      over <= 1'b1;
      wdiag(dpm_pkg::DIAG_HV_FIRST, 30, n); chk(32'(hv_en), 32'h0000_0001);
      @(posedge clk);
      over <= 1'b0;
      repeat (40) @(posedge clk);
      over <= 1'b1;
      wdiag(dpm_pkg::DIAG_HV_FIRST, 30, n);
      wdiag(dpm_pkg::DIAG_HV_TRIP, 50, n); chk(n, 39);
      chk(32'(hv_en), 32'h0000_0000);
      @(posedge clk);
      over <= 1'b0;
      rd(dpm_pkg::REG_STATUS, q); chk(32'(q[1:0]), 32'h0000_0003);
      // sixth tick after reset was the tripping sample, door motor off
      wr(dpm_pkg::REG_HIST_INDEX, 32'h0000_0005);
      rd(dpm_pkg::REG_HIST_DATA, q); chk(q, 32'h0008_0c01);
   endtask : t_clp
   task automatic t_ramp();
      // limits and step values stay at their loaded defaults
      wr(dpm_pkg::REG_DAC, 32'h0000_0000);
      wr(dpm_pkg::REG_CONTROL, 32'h0000_0003);
      wdac(12'h010, 1200, n);
      wdac(12'h020, 1100, n); chk(n, 999);
      rd(dpm_pkg::REG_STATUS, q); chk(32'(q[5]), 32'h0000_0001);
      wr(dpm_pkg::REG_CEILING, 32'h0000_0018);
      repeat (3) @(posedge clk);
      #1;
      chk(32'(dac), 32'h0000_0018);
      rd(dpm_pkg::REG_CEILING, q); chk(q, 32'h0000_0018);
   endtask : t_ramp
   task automatic t_crp();
      wr(dpm_pkg::REG_CEILING, 32'h0000_0800);
      wr(dpm_pkg::REG_DAC, 32'h0000_0200);
      wr(dpm_pkg::REG_RATE_LIMIT, 32'h0000_0010);
      wr(dpm_pkg::REG_CONTROL, 32'h0000_0003);
      burst <= 1'b1;
      wdiag(dpm_pkg::DIAG_CRP, 5100, n);
      repeat (2) @(posedge clk);
      chk(32'(dac), 32'h0000_0100);
      rd(dpm_pkg::REG_STATUS, q); chk(32'(q[5]), 32'h0000_0000);
      wr(dpm_pkg::REG_DAC, 32'h0000_0050);
      wdiag(dpm_pkg::DIAG_CRP, 5100, n);
      repeat (2) @(posedge clk);
      chk(32'(dac), 32'h0000_0050);
      burst <= 1'b0;
      // the average decays slowly; a late rate pulse would abut the door pulse
      wr(dpm_pkg::REG_RATE_LIMIT, 32'h0000_ffff);
   endtask : t_crp
   task automatic t_door();
      wr(dpm_pkg::REG_MOTOR_TIMER, 32'h0000_0055);
      wr(dpm_pkg::REG_DOOR_CTRL, 32'h0000_007f);
      lcmd <= ~lcmd;
      #1;
      for (n = 0; n < 12000 && door !== 7'h00; n++) begin
         @(posedge clk);
         #1;
      end
      chk(32'(n > 4990 && n < 10020), 32'h0000_0001);
      if (n >= 12000) summarize();
      rd(dpm_pkg::REG_MOTOR_TIMER, q); chk(q, 32'h0000_0000);
      wr(dpm_pkg::REG_DOOR_TIMER, 32'h0000_0064);
      wr(dpm_pkg::REG_DOOR_CTRL, 32'h0000_007f);
      aux_hi <= 1'b1;
      wdiag(dpm_pkg::DIAG_AUX_DOOR, 15100, n); chk(32'(door), 32'h0000_0000);
      rd(dpm_pkg::REG_STATUS, q); chk(32'(q[4]), 32'h0000_0001);
      aux_hi <= 1'b0;
   endtask : t_door
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_clp();
      t_ramp();
      t_crp();
      t_door();
      summarize();
   end
endmodule : dpm_top_test
`default_nettype wire
